// ==== shared/jbst_defs.svh ====
`ifndef JBST_DEFS_SVH
`define JBST_DEFS_SVH

`define JBST_IR_LEN 10
`define JBST_BSR_LEN 690
`define JBST_SIG_LEN 32
`define JBST_USER_BITS 7
// Fixed upper bits of the user signature (arbitrary value)
`define JBST_SIG_FIXED 25'h0A5_5A5A
// Identification value (arbitrary value)
`define JBST_ID_VALUE 32'h1234_5679
`define JBST_OP_EXTEST 10'h000
`define JBST_OP_SAMPLE 10'h055
`define JBST_OP_IDCODE 10'h059
`define JBST_OP_USERCODE 10'h079
`define JBST_OP_CFG_LOAD 10'h002
`define JBST_OP_CFG_START 10'h003
`define JBST_OP_BYPASS 10'h3FF
// Captured into the instruction register, low bits 01
`define JBST_IR_CAPTURE 10'h001

`endif

// ==== shared/jbst_pkg.sv ====
`include "jbst_defs.svh"
package jbst_pkg;
  typedef enum logic [15:0] {
    JB_RESET = 16'h0001, JB_IDLE = 16'h0002, JB_SEL_DR = 16'h0004, JB_CAP_DR = 16'h0008,
    JB_SHIFT_DR = 16'h0010, JB_EXIT1_DR = 16'h0020, JB_PAUSE_DR = 16'h0040,
    JB_EXIT2_DR = 16'h0080, JB_UPD_DR = 16'h0100, JB_SEL_IR = 16'h0200,
    JB_CAP_IR = 16'h0400, JB_SHIFT_IR = 16'h0800, JB_EXIT1_IR = 16'h1000,
    JB_PAUSE_IR = 16'h2000, JB_EXIT2_IR = 16'h4000, JB_UPD_IR = 16'h8000
  } jb_tap_e;

  typedef enum logic [5:0] {
    JB_SEL_BYPASS = 6'h01, JB_SEL_ID = 6'h02, JB_SEL_USER = 6'h04,
    JB_SEL_BOUND = 6'h08, JB_SEL_CFG = 6'h10, JB_SEL_NONE = 6'h20
  } jb_dsel_e;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } jb_pins_s;

  typedef struct packed {
    logic [2:0] tck_sync;
    logic [1:0] tms_sync;
    logic [1:0] tdi_sync;
    logic [1:0] trst_sync;
    jb_tap_e tap;
    logic [`JBST_IR_LEN-1:0] ir_shift;
    logic [`JBST_IR_LEN-1:0] ir;
    logic bypass;
    logic [`JBST_SIG_LEN-1:0] dr32;
    logic [`JBST_BSR_LEN-1:0] bsr_shift;
    logic [`JBST_BSR_LEN-1:0] bsr_upd;
    logic [7:0] cfg_shift;
    logic [7:0] cfg_byte;
    logic cfg_strobe;
    logic tdo;
    logic tdo_en_n;
    logic pins_en_n;
  } jb_state_s;
endpackage

// ==== hw/jbst_tap.sv ====
`timescale 1ns/1ns
`include "jbst_defs.svh"

// Summary of operation
// (RULE1) Standard sixteen-state controller and instruction flow
// (RULE2) Instruction register shifts exactly ten bits
// (RULE3) BYPASS inserts one-bit register
// (RULE4) USERCODE shifts out the user signature
// (RULE5) Signature: seven user bits, 25 fixed
// (RULE6) IDCODE shifts out identification value
// (RULE7) SAMPLE/PRELOAD captures pins, preloads pattern
// (RULE8) EXTEST drives pattern, captures input pins
// (RULE9) Boundary chain length set per density
// (RULE10) No scan testing while configuring (only the EXTEST pin override is blocked; scans still shift)
// (RULE11) Configuration instructions load data via port
// (RULE12) Outputs undriven until operating conditions reached
// (RULE13) Opcodes parameters; unknown selects bypass
// (RULE14) Capture/shift rising, update falling test clock
module jbst_tap #(
  parameter logic [`JBST_IR_LEN-1:0] OP_EXTEST = `JBST_OP_EXTEST,
  parameter logic [`JBST_IR_LEN-1:0] OP_SAMPLE = `JBST_OP_SAMPLE,
  parameter logic [`JBST_IR_LEN-1:0] OP_IDCODE = `JBST_OP_IDCODE,
  parameter logic [`JBST_IR_LEN-1:0] OP_USERCODE = `JBST_OP_USERCODE,
  parameter logic [`JBST_IR_LEN-1:0] OP_CFG_LOAD = `JBST_OP_CFG_LOAD,
  parameter logic [`JBST_IR_LEN-1:0] OP_BYPASS = `JBST_OP_BYPASS,
  parameter logic [`JBST_SIG_LEN-1:0] ID_VALUE = `JBST_ID_VALUE
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire jbst_pkg::jb_pins_s jtag_in,
  input wire logic power_good_in,
  input wire logic configuring_in,
  input wire logic [`JBST_USER_BITS-1:0] user_sig_in,
  input wire logic [`JBST_BSR_LEN-1:0] pin_levels_in,
  output logic tdo_out,
  output logic tdo_en_n_out,
  output logic [`JBST_BSR_LEN-1:0] pin_drive_out,
  output logic pin_override_n_out,
  output logic [7:0] cfg_byte_out,
  output logic cfg_strobe_out
);

  jbst_pkg::jb_state_s st;
  jbst_pkg::jb_state_s next_st;

  // Next controller state from current state and mode bit
  function automatic jbst_pkg::jb_tap_e tap_next(input jbst_pkg::jb_tap_e s, input logic m);
    case (s)
      jbst_pkg::JB_RESET: begin
        if (m) begin
          tap_next = jbst_pkg::JB_RESET;
        end else begin
          tap_next = jbst_pkg::JB_IDLE;
        end
      end
      jbst_pkg::JB_IDLE: begin
        if (m) begin
          tap_next = jbst_pkg::JB_SEL_DR;
        end else begin
          tap_next = jbst_pkg::JB_IDLE;
        end
      end
      jbst_pkg::JB_SEL_DR: begin
        if (m) begin
          tap_next = jbst_pkg::JB_SEL_IR;
        end else begin
          tap_next = jbst_pkg::JB_CAP_DR;
        end
      end
      jbst_pkg::JB_CAP_DR: begin
        if (m) begin
          tap_next = jbst_pkg::JB_EXIT1_DR;
        end else begin
          tap_next = jbst_pkg::JB_SHIFT_DR;
        end
      end
      jbst_pkg::JB_SHIFT_DR: begin
        if (m) begin
          tap_next = jbst_pkg::JB_EXIT1_DR;
        end else begin
          tap_next = jbst_pkg::JB_SHIFT_DR;
        end
      end
      jbst_pkg::JB_EXIT1_DR: begin
        if (m) begin
          tap_next = jbst_pkg::JB_UPD_DR;
        end else begin
          tap_next = jbst_pkg::JB_PAUSE_DR;
        end
      end
      jbst_pkg::JB_PAUSE_DR: begin
        if (m) begin
          tap_next = jbst_pkg::JB_EXIT2_DR;
        end else begin
          tap_next = jbst_pkg::JB_PAUSE_DR;
        end
      end
      jbst_pkg::JB_EXIT2_DR: begin
        if (m) begin
          tap_next = jbst_pkg::JB_UPD_DR;
        end else begin
          tap_next = jbst_pkg::JB_SHIFT_DR;
        end
      end
      jbst_pkg::JB_UPD_DR: begin
        if (m) begin
          tap_next = jbst_pkg::JB_SEL_DR;
        end else begin
          tap_next = jbst_pkg::JB_IDLE;
        end
      end
      jbst_pkg::JB_SEL_IR: begin
        if (m) begin
          tap_next = jbst_pkg::JB_RESET;
        end else begin
          tap_next = jbst_pkg::JB_CAP_IR;
        end
      end
      jbst_pkg::JB_CAP_IR: begin
        if (m) begin
          tap_next = jbst_pkg::JB_EXIT1_IR;
        end else begin
          tap_next = jbst_pkg::JB_SHIFT_IR;
        end
      end
      jbst_pkg::JB_SHIFT_IR: begin
        if (m) begin
          tap_next = jbst_pkg::JB_EXIT1_IR;
        end else begin
          tap_next = jbst_pkg::JB_SHIFT_IR;
        end
      end
      jbst_pkg::JB_EXIT1_IR: begin
        if (m) begin
          tap_next = jbst_pkg::JB_UPD_IR;
        end else begin
          tap_next = jbst_pkg::JB_PAUSE_IR;
        end
      end
      jbst_pkg::JB_PAUSE_IR: begin
        if (m) begin
          tap_next = jbst_pkg::JB_EXIT2_IR;
        end else begin
          tap_next = jbst_pkg::JB_PAUSE_IR;
        end
      end
      jbst_pkg::JB_EXIT2_IR: begin
        if (m) begin
          tap_next = jbst_pkg::JB_UPD_IR;
        end else begin
          tap_next = jbst_pkg::JB_SHIFT_IR;
        end
      end
      jbst_pkg::JB_UPD_IR: begin
        if (m) begin
          tap_next = jbst_pkg::JB_SEL_DR;
        end else begin
          tap_next = jbst_pkg::JB_IDLE;
        end
      end
      default: tap_next = jbst_pkg::JB_RESET;
    endcase
  endfunction

  // Data register selected by an instruction
  function automatic jbst_pkg::jb_dsel_e decode(input logic [`JBST_IR_LEN-1:0] op);
    // (RULE13) unknown opcode bypass
    decode = jbst_pkg::JB_SEL_BYPASS;
    if (op == OP_IDCODE) begin
      decode = jbst_pkg::JB_SEL_ID;
    end else if (op == OP_USERCODE) begin
      decode = jbst_pkg::JB_SEL_USER;
    end else if (op == OP_EXTEST || op == OP_SAMPLE) begin
      decode = jbst_pkg::JB_SEL_BOUND;
    end else if (op == OP_CFG_LOAD) begin
      decode = jbst_pkg::JB_SEL_CFG;
    end else if (op == OP_BYPASS) begin
      decode = jbst_pkg::JB_SEL_BYPASS;
    end
  endfunction

  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  jbst_pkg::jb_dsel_e dsel;
  logic shift_out;

  assign tck_rise = st.tck_sync[1] & ~st.tck_sync[2];
  assign tck_fall = ~st.tck_sync[1] & st.tck_sync[2];
  assign tms = st.tms_sync[1];
  assign tdi = st.tdi_sync[1];
  assign dsel = decode(st.ir);

  always_comb begin
    next_st = st;
    next_st.tck_sync = {st.tck_sync[1], st.tck_sync[0], jtag_in.tck};
    next_st.tms_sync = {st.tms_sync[0], jtag_in.tms};
    next_st.tdi_sync = {st.tdi_sync[0], jtag_in.tdi};
    next_st.trst_sync = {st.trst_sync[0], jtag_in.trst_n};
    next_st.cfg_strobe = 1'b0;
    shift_out = st.bypass;
    case (st.tap)
      jbst_pkg::JB_SHIFT_IR: shift_out = st.ir_shift[0];
      default: begin
        case (dsel)
          jbst_pkg::JB_SEL_ID: shift_out = st.dr32[0];
          jbst_pkg::JB_SEL_USER: shift_out = st.dr32[0];
          jbst_pkg::JB_SEL_BOUND: shift_out = st.bsr_shift[0];
          jbst_pkg::JB_SEL_CFG: shift_out = st.cfg_shift[0];
          default: shift_out = st.bypass;
        endcase
      end
    endcase
    // (RULE14) rising edge capture and shift
    if (tck_rise) begin
      next_st.tap = tap_next(st.tap, tms);
      case (st.tap)
        jbst_pkg::JB_RESET: begin
          next_st.ir = OP_IDCODE;
        end
        jbst_pkg::JB_CAP_IR: begin
          next_st.ir_shift = `JBST_IR_CAPTURE;
        end
        // (RULE2) ten-bit instruction shift
        jbst_pkg::JB_SHIFT_IR: begin
          next_st.ir_shift = {tdi, st.ir_shift[`JBST_IR_LEN-1:1]};
        end
        jbst_pkg::JB_CAP_DR: begin
          case (dsel)
            // (RULE6) load identification value
            jbst_pkg::JB_SEL_ID: next_st.dr32 = ID_VALUE;
            // (RULE5) fixed and user bits
            jbst_pkg::JB_SEL_USER: next_st.dr32 = {`JBST_SIG_FIXED, user_sig_in};
            // (RULE7) snapshot of pin levels
            jbst_pkg::JB_SEL_BOUND: next_st.bsr_shift = pin_levels_in;
            default: next_st.bypass = 1'b0;
          endcase
        end
        jbst_pkg::JB_SHIFT_DR: begin
          case (dsel)
            // (RULE4) signature shifts out serially
            jbst_pkg::JB_SEL_ID, jbst_pkg::JB_SEL_USER: begin
              next_st.dr32 = {tdi, st.dr32[`JBST_SIG_LEN-1:1]};
            end
            // (RULE9) chain length per density
            jbst_pkg::JB_SEL_BOUND: begin
              next_st.bsr_shift = {tdi, st.bsr_shift[`JBST_BSR_LEN-1:1]};
            end
            // (RULE11) configuration data shift
            jbst_pkg::JB_SEL_CFG: begin
              next_st.cfg_shift = {tdi, st.cfg_shift[7:1]};
            end
            // (RULE3) one-bit bypass path
            default: next_st.bypass = tdi;
          endcase
        end
        default: begin
        end
      endcase
    end
    // (RULE14) falling edge updates
    if (tck_fall) begin
      next_st.tdo = shift_out;
      next_st.tdo_en_n = ~(st.tap == jbst_pkg::JB_SHIFT_IR || st.tap == jbst_pkg::JB_SHIFT_DR);
      case (st.tap)
        // (RULE1) instruction takes effect at update
        jbst_pkg::JB_UPD_IR: next_st.ir = st.ir_shift;
        jbst_pkg::JB_UPD_DR: begin
          if (dsel == jbst_pkg::JB_SEL_BOUND) begin
            next_st.bsr_upd = st.bsr_shift;
          end
          if (dsel == jbst_pkg::JB_SEL_CFG) begin
            next_st.cfg_byte = st.cfg_shift;
            next_st.cfg_strobe = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // (RULE8) pattern drives pins in extest
    next_st.pins_en_n = ~(st.ir == OP_EXTEST);
    // (RULE10) EXTEST pin override blocked when configuring; shifting and capture go on
    if (configuring_in && st.ir == OP_EXTEST) begin
      next_st.pins_en_n = 1'b1;
    end
    // Test reset releases pins on the third clock after trst_n falls, even mid-shift
    if (!st.trst_sync[1]) begin
      next_st.tap = jbst_pkg::JB_RESET;
      next_st.ir = OP_IDCODE;
      next_st.tdo_en_n = 1'b1;
      next_st.pins_en_n = 1'b1;
    end
    // (RULE12) undriven during power-up
    if (!power_good_in) begin
      next_st.tdo_en_n = 1'b1;
      next_st.pins_en_n = 1'b1;
      next_st.tap = jbst_pkg::JB_RESET;
      next_st.ir = OP_IDCODE;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st <= '0;
      st.tap <= jbst_pkg::JB_RESET;
      st.ir <= OP_IDCODE;
      st.trst_sync <= 2'h3;
      st.tdo_en_n <= 1'b1;
      st.pins_en_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign tdo_out = st.tdo;
  assign tdo_en_n_out = st.tdo_en_n;
  assign pin_drive_out = st.bsr_upd;
  assign pin_override_n_out = st.pins_en_n;
  assign cfg_byte_out = st.cfg_byte;
  assign cfg_strobe_out = st.cfg_strobe;

endmodule

// ==== bench/jbst_tap_checker.sv ====
`timescale 1ns/1ns
`include "jbst_defs.svh"
module jbst_tap_checker (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire jbst_pkg::jb_pins_s jtag_in,
  input wire logic power_good_in,
  input wire logic configuring_in,
  input wire logic tdo_out,
  input wire logic tdo_en_n_out,
  input wire logic [`JBST_BSR_LEN-1:0] pin_drive_out,
  input wire logic pin_override_n_out,
  input wire logic [7:0] cfg_byte_out,
  input wire logic cfg_strobe_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  chk_reset_quiet:
    assert property ($fell(rst_in) |-> tdo_en_n_out && pin_override_n_out && !cfg_strobe_out)
    else $error("outputs active after reset");
  chk_power_off:
    assert property (!power_good_in |=> tdo_en_n_out && pin_override_n_out)
    else $error("outputs driven without power");
  chk_cfg_blocks:
    assert property (configuring_in ##1 configuring_in |-> pin_override_n_out)
    else $error("pins overridden while configuring");
  chk_override_cause:
    assert property (!pin_override_n_out |-> !$past(configuring_in) && $past(power_good_in))
    else $error("override without cause");
  chk_strobe_pulse:
    assert property (cfg_strobe_out |=> !cfg_strobe_out)
    else $error("strobe longer than one cycle");
  chk_byte_strobe:
    assert property ($changed(cfg_byte_out) |-> cfg_strobe_out)
    else $error("byte changed without strobe");
  chk_drive_fall:
    assert property ($changed(pin_drive_out) |-> !$past(jtag_in.tck, 2))
    else $error("pin pattern changed on rising test clock");
  chk_tdo_fall:
    assert property ($changed(tdo_out) |-> !$past(jtag_in.tck, 2))
    else $error("serial out changed on rising test clock");
  chk_trst_reset:
    assert property (!jtag_in.trst_n [*4] |-> tdo_en_n_out && pin_override_n_out)
    else $error("test reset ignored");
  cover property (cfg_strobe_out);
  cover property (!pin_override_n_out);
  cover property (!tdo_en_n_out && power_good_in);
endmodule
bind jbst_tap jbst_tap_checker u_chk (.clock_in, .rst_in, .jtag_in, .power_good_in,
  .configuring_in, .tdo_out, .tdo_en_n_out, .pin_drive_out, .pin_override_n_out,
  .cfg_byte_out, .cfg_strobe_out);

// ==== bench/jbst_ctl.sv ====
`timescale 1ns/1ns
module jbst_ctl (
  input wire logic clock_in,
  input wire logic tdo_in,
  output jbst_pkg::jb_pins_s pins_out
);
  logic odd;
  initial begin
    pins_out = 4'b0101;
    odd = 1'b0;
  end
  // set while low, sample before rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    pins_out.tms <= tms;
    pins_out.tdi <= tdi;
    repeat (odd ? 7 : 6) @(posedge clock_in);
    odd = ~odd;
    tdo = tdo_in;
    pins_out.tck <= 1'b1;
    repeat (6) @(posedge clock_in);
    pins_out.tck <= 1'b0;
  endtask
  task automatic tap_reset(input logic use_trst);
    logic b;
    if (use_trst) begin
      pins_out.trst_n <= 1'b0;
      repeat (6) @(posedge clock_in);
      pins_out.trst_n <= 1'b1;
    end else begin
      repeat (5) step(1'b1, 1'b0, b);
    end
    step(1'b0, 1'b0, b);
  endtask
  // idle to shift, LSB first, back to idle
  task automatic scan(input logic ir, input int n, input logic [1023:0] din,
                      output logic [1023:0] dout);
    logic b;
    dout = '0;
    step(1'b1, 1'b0, b);
    if (ir) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask
endmodule

// ==== bench/jbst_tap_bench.sv ====
`timescale 1ns/1ns
`include "jbst_defs.svh"
module jbst_tap_bench;
  logic clock_in, rst_in, power_good, configuring, tdo, tdo_en_n, override_n, strobe;
  logic [6:0] user_sig;
  logic [`JBST_BSR_LEN-1:0] levels, drive;
  logic [7:0] cfg_byte;
  logic [1023:0] got;
  jbst_pkg::jb_pins_s pins;
  int err_count, tests_run, strobe_count;
  // Strobe stands one cycle, so count pulses rather than look once
  always @(posedge clock_in) begin
    if (strobe === 1'b1) strobe_count++;
  end
  jbst_tap DUT (.clock_in(clock_in), .rst_in(rst_in), .jtag_in(pins),
    .power_good_in(power_good), .configuring_in(configuring), .user_sig_in(user_sig),
    .pin_levels_in(levels), .tdo_out(tdo), .tdo_en_n_out(tdo_en_n), .pin_drive_out(drive),
    .pin_override_n_out(override_n), .cfg_byte_out(cfg_byte), .cfg_strobe_out(strobe));
  jbst_ctl ctl (.clock_in(clock_in), .tdo_in(tdo), .pins_out(pins));
  task automatic check(input string what, input logic [1023:0] exp, input logic [1023:0] seen);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_user();
    ctl.tap_reset(1'b0);
    ctl.scan(1'b0, 32, '0, got);
    check("idcode", `JBST_ID_VALUE, got);
    ctl.scan(1'b1, 12, {`JBST_OP_USERCODE, 2'b11}, got);
    check("ir capture", 12'hC01, got);
    ctl.scan(1'b0, 32, '0, got);
    check("usercode", {`JBST_SIG_FIXED, user_sig}, got);
    ctl.tap_reset(1'b1);
    ctl.scan(1'b0, 32, '0, got);
    check("id after trst", `JBST_ID_VALUE, got);
    $display("test user done");
  endtask
  task automatic t_bypass(input logic [9:0] op);
    ctl.scan(1'b1, 10, op, got);
    ctl.scan(1'b0, 8, 8'hA5, got);
    check("bypass", 8'h4A, got);
    $display("test bypass %0h done", op);
  endtask
  task automatic t_bound();
    levels <= {(`JBST_BSR_LEN / 2){2'b10}};
    ctl.scan(1'b1, 10, `JBST_OP_SAMPLE, got);
    ctl.scan(1'b0, `JBST_BSR_LEN, {(`JBST_BSR_LEN / 2){2'b01}}, got);
    check("sample", levels, got);
    check("sample keeps pins", 1'b1, override_n);
    ctl.scan(1'b1, 10, `JBST_OP_EXTEST, got);
    check("preload", {(`JBST_BSR_LEN / 2){2'b01}}, drive);
    check("extest drives", 1'b0, override_n);
    levels <= ~levels;
    ctl.scan(1'b0, `JBST_BSR_LEN, '0, got);
    check("extest capture", levels, got);
    check("extest pattern", '0, drive);
    configuring <= 1'b1;
    repeat (4) @(posedge clock_in);
    check("config blocks", 1'b1, override_n);
    configuring <= 1'b0;
    $display("test boundary done");
  endtask
  task automatic t_cfg_power();
    logic b;
    ctl.scan(1'b1, 10, `JBST_OP_CFG_LOAD, got);
    ctl.scan(1'b0, 8, 8'h3C, got);
    check("cfg byte", 8'h3C, cfg_byte);
    check("cfg strobes", 1, strobe_count);
    ctl.scan(1'b1, 10, `JBST_OP_EXTEST, got);
    // Park in Shift-DR so both outputs are active when power drops
    ctl.step(1'b1, 1'b0, b);
    ctl.step(1'b0, 1'b0, b);
    ctl.step(1'b0, 1'b0, b);
    repeat (8) @(posedge clock_in);
    check("shift drives tdo", 1'b0, tdo_en_n);
    check("extest before drop", 1'b0, override_n);
    power_good <= 1'b0;
    repeat (4) @(posedge clock_in);
    check("no power tdo", 1'b1, tdo_en_n);
    check("no power pins", 1'b1, override_n);
    power_good <= 1'b1;
    repeat (4) @(posedge clock_in);
    check("power back pins", 1'b1, override_n);
    ctl.tap_reset(1'b0);
    ctl.scan(1'b0, 32, '0, got);
    check("id after power", `JBST_ID_VALUE, got);
    $display("test config and power done");
  endtask
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  initial begin
    repeat (60000) @(posedge clock_in);
    err_count++;
    stop_test();
  end
  initial begin
    rst_in = 1'b1;
    power_good = 1'b1;
    configuring = 1'b0;
    user_sig = 7'h5B;
    levels = '0;
    err_count = 0;
    tests_run = 0;
    strobe_count = 0;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    t_user();
    t_bypass(`JBST_OP_BYPASS);
    t_bypass(10'h2AA);
    t_bound();
    t_cfg_power();
    stop_test();
  end
endmodule
